// ===== pcc_pkg.sv
// pcc_pkg: constants, register map and carriers for the pairing coprocessor sequencer.
// assumes a single APB clock domain; arithmetic datapath lives outside.
package pcc_pkg;

  // memory geometry (log2 sizes are what software reads back)
  localparam int IM_AW    = 4;
  localparam int IM_DEPTH = 16;
  localparam int DM_AW    = 4;
  localparam int DM_DEPTH = 16;
  localparam int VAL_W    = 381;
  localparam int TAG_W    = 3;
  localparam int SLOT_WORDS = 12;  // 48 stored bytes of a 64-byte slot

  // apb map (byte addresses)
  localparam logic [15:0] REG_CTRL    = 16'h0000;
  localparam logic [15:0] REG_DM_OFS  = 16'h0004;
  localparam logic [15:0] REG_DM_SIZE = 16'h0008;
  localparam logic [15:0] REG_IM_SIZE = 16'h000C;
  localparam logic [15:0] REG_IP      = 16'h0010;
  localparam logic [15:0] REG_LASTCYC = 16'h0014;
  localparam logic [3:0]  RGN_REG     = 4'h0;
  localparam logic [3:0]  RGN_IMEM    = 4'h1;
  localparam logic [3:0]  RGN_DMEM    = 4'h2;
  localparam logic [31:0] IMEM_BASE   = 32'h0000_1000;
  localparam logic [31:0] DMEM_BASE   = 32'h0000_2000;
  localparam int CTRL_IMEM_CLR = 0;
  localparam int CTRL_DMEM_CLR = 1;

  // operation codes
  localparam logic [7:0] OP_IDLE    = 8'h00;
  localparam logic [7:0] OP_COPY    = 8'h01;
  localparam logic [7:0] OP_JUMP    = 8'h02;
  localparam logic [7:0] OP_JZ      = 8'h03;
  localparam logic [7:0] OP_JEQ     = 8'h04;
  localparam logic [7:0] OP_JNZ     = 8'h05;
  localparam logic [7:0] OP_NOTIFY  = 8'h06;
  localparam logic [7:0] OP_FMUL    = 8'h10;
  localparam logic [7:0] OP_FADD    = 8'h11;
  localparam logic [7:0] OP_FSUB    = 8'h12;
  localparam logic [7:0] OP_FINV    = 8'h13;
  localparam logic [7:0] OP_PNEG    = 8'h20;
  localparam logic [7:0] OP_PADD    = 8'h21;
  localparam logic [7:0] OP_PMUL    = 8'h22;
  localparam logic [7:0] OP_G1MUL   = 8'h23;
  localparam logic [7:0] OP_G2MUL   = 8'h24;
  localparam logic [7:0] OP_PAIRING = 8'h28;

  // type tags
  localparam logic [2:0] TAG_SCALAR = 3'h0;
  localparam logic [2:0] TAG_FP     = 3'h1;
  localparam logic [2:0] TAG_FP2    = 3'h2;
  localparam logic [2:0] TAG_FP12   = 3'h3;
  localparam logic [2:0] TAG_G1_AFF = 3'h4;
  localparam logic [2:0] TAG_G1_JAC = 3'h5;
  localparam logic [2:0] TAG_G2_AFF = 3'h6;
  localparam logic [2:0] TAG_G2_JAC = 3'h7;

  typedef struct packed {
    logic [TAG_W-1:0] tag;
    logic [VAL_W-1:0] val;
  } pcc_slot_t;

  typedef struct packed {
    logic [7:0]  rsv;
    logic [15:0] c;
    logic [15:0] b;
    logic [15:0] a;
    logic [7:0]  op;
  } pcc_instr_t;

  localparam pcc_instr_t IDLE_INSTR = 64'h0000_0000_0000_0000;

  // consecutive slots an operand of a given tag spans
  function automatic logic [3:0] slot_span(input logic [2:0] tag);
    case (tag)
      TAG_FP2, TAG_G1_AFF: slot_span = 4'h2;
      TAG_FP12:            slot_span = 4'hC;
      TAG_G1_JAC:          slot_span = 4'h3;
      TAG_G2_AFF:          slot_span = 4'h4;
      TAG_G2_JAC:          slot_span = 4'h6;
      default:             slot_span = 4'h1;
    endcase
  endfunction

endpackage

// ===== pcc_seq.sv
// pcc_seq: instruction fetch/decode sequencer of the pairing coprocessor,
// with APB register file, instruction memory and slotted data memory.
// assumes an external arithmetic unit on the ar_* port and a host sink on nt_*.
`timescale 1ns/1ps
`default_nettype none

module pcc_seq (
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [15:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic [31:0]              prdata,
  output logic                     pslverr,
  // arithmetic unit
  output logic                     ar_req,
  output logic [7:0]               ar_op,
  output pcc_pkg::pcc_slot_t       ar_a,
  output pcc_pkg::pcc_slot_t       ar_b,
  input  wire logic                ar_done,
  input  wire pcc_pkg::pcc_slot_t  ar_res,
  // notify message to host
  output logic                     nt_valid,
  output logic [15:0]              nt_hdr,
  output logic [2:0]               nt_tag,
  output pcc_pkg::pcc_slot_t       nt_data,
  output logic                     nt_last,
  input  wire logic                nt_ready
);

  typedef enum logic [1:0] {S_FETCH, S_EXEC, S_ARITH, S_NOTIFY} pcc_state_t;

  pcc_pkg::pcc_instr_t               imem_r [pcc_pkg::IM_DEPTH];
  pcc_pkg::pcc_slot_t                dmem_r [pcc_pkg::DM_DEPTH];
  pcc_state_t                        state_r;
  pcc_pkg::pcc_instr_t               cur_r;
  logic [pcc_pkg::IM_AW-1:0]         ip_r;
  logic                              ip_pend_r;
  logic [pcc_pkg::IM_AW-1:0]         ip_pend_val_r;
  logic [31:0]                       cyc_r;
  logic [31:0]                       last_cyc_r;
  logic [pcc_pkg::DM_AW-1:0]         nt_idx_r;
  logic [3:0]                        nt_rem_r;
  logic [pcc_pkg::DM_AW-1:0]         dst_r;

  // apb decode
  logic                              wr_acc;
  logic [3:0]                        rgn;
  logic                              im_hit;
  logic                              dm_hit;
  logic [pcc_pkg::IM_AW-1:0]         im_idx;
  logic [pcc_pkg::DM_AW-1:0]         dm_idx;
  logic [3:0]                        dm_word;
  logic                              imem_clr;
  logic                              dmem_clr;
  logic                              apb_ip_we;
  logic [31:0]                       rd_data;
  logic                              rd_err;

  // operand views of the current instruction
  logic [pcc_pkg::DM_AW-1:0]         sa;
  logic [pcc_pkg::DM_AW-1:0]         sb;
  logic [pcc_pkg::DM_AW-1:0]         sc;
  logic                              b_zero;
  logic                              b_eq_c;
  logic                              seq_we;
  logic [pcc_pkg::DM_AW-1:0]         seq_idx;
  pcc_pkg::pcc_slot_t                seq_val;

  assign wr_acc  = psel & penable & pready & pwrite;
  assign rgn     = paddr[15:12];
  assign im_hit  = (rgn == pcc_pkg::RGN_IMEM) && (paddr[11:7] == 5'h00);
  assign dm_hit  = (rgn == pcc_pkg::RGN_DMEM) && (paddr[11:10] == 2'h0);
  assign im_idx  = paddr[6:3];
  assign dm_idx  = paddr[9:6];       // 64-byte slot stride
  assign dm_word = paddr[5:2];

  assign imem_clr  = wr_acc && paddr == pcc_pkg::REG_CTRL
                     && pwdata[pcc_pkg::CTRL_IMEM_CLR];
  assign dmem_clr  = wr_acc && paddr == pcc_pkg::REG_CTRL
                     && pwdata[pcc_pkg::CTRL_DMEM_CLR];
  assign apb_ip_we = wr_acc && paddr == pcc_pkg::REG_IP;

  // operands sit above the opcode byte
  assign sa     = cur_r.a[pcc_pkg::DM_AW-1:0];
  assign sb     = cur_r.b[pcc_pkg::DM_AW-1:0];
  assign sc     = cur_r.c[pcc_pkg::DM_AW-1:0];
  assign b_zero = (dmem_r[sb].val == '0);
  assign b_eq_c = (dmem_r[sb].val == dmem_r[sc].val);

  // apb read mux; words 12..15 of a slot are address space only
  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    if (rgn == pcc_pkg::RGN_REG)
    begin
      case (paddr)
        pcc_pkg::REG_CTRL:    rd_data = pcc_pkg::IMEM_BASE;
        pcc_pkg::REG_DM_OFS:  rd_data = pcc_pkg::DMEM_BASE;
        pcc_pkg::REG_DM_SIZE: rd_data = 32'(pcc_pkg::DM_AW);
        pcc_pkg::REG_IM_SIZE: rd_data = 32'(pcc_pkg::IM_AW);
        pcc_pkg::REG_IP:      rd_data = 32'(ip_r);
        pcc_pkg::REG_LASTCYC: rd_data = last_cyc_r;
        default:              rd_err  = 1'b1;
      endcase
    end
    else if (im_hit)
      rd_data = paddr[2] ? imem_r[im_idx][63:32] : imem_r[im_idx][31:0];
    else if (dm_hit)
    begin
      if (dm_word < 4'(pcc_pkg::SLOT_WORDS))
        rd_data = dmem_r[dm_idx][{dm_word, 5'h00} +: 32];
    end
    else
      rd_err = 1'b1;
  end

  // zero-wait apb: answer is prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable;
      if (psel & ~penable)
      begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_data;
        pslverr <= rd_err;
      end
    end
  end

  // instruction memory, one store per location
  genvar gi;
  generate
    for (gi = 0; gi < pcc_pkg::IM_DEPTH; gi++)
    begin : g_imem
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          imem_r[gi] <= pcc_pkg::IDLE_INSTR;
        else if (imem_clr)
          imem_r[gi] <= pcc_pkg::IDLE_INSTR;
        else if (wr_acc && im_hit && im_idx == gi)
        begin
          if (paddr[2])
            imem_r[gi][63:32] <= pwdata;
          else
            imem_r[gi][31:0] <= pwdata;
        end
      end
    end
  endgenerate

  // data memory: clear beats sequencer beats software
  generate
    for (gi = 0; gi < pcc_pkg::DM_DEPTH; gi++)
    begin : g_dmem
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          dmem_r[gi] <= '0;
        else if (dmem_clr)
          dmem_r[gi] <= '0;
        else if (seq_we && seq_idx == gi)
          dmem_r[gi] <= seq_val;
        else if (wr_acc && dm_hit && dm_idx == gi
                 && dm_word < 4'(pcc_pkg::SLOT_WORDS))
          dmem_r[gi][{dm_word, 5'h00} +: 32] <= pwdata;
      end
    end
  endgenerate

  // sequencer-side data memory writes
  always_comb
  begin
    seq_we  = 1'b0;
    seq_idx = sb;
    seq_val = dmem_r[sa];
    if (state_r == S_EXEC && cur_r.op == pcc_pkg::OP_COPY)
      seq_we = 1'b1;
    else if (state_r == S_EXEC && cur_r.op == pcc_pkg::OP_JNZ && !b_zero)
    begin
      seq_we      = 1'b1;
      seq_val     = dmem_r[sb];
      seq_val.val = dmem_r[sb].val - 381'h1;
    end
    else if (state_r == S_ARITH && ar_done)
    begin
      seq_we  = 1'b1;
      seq_idx = dst_r;
      seq_val = ar_res;
    end
  end

  // fetch, decode and control flow
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r       <= S_FETCH;
      cur_r         <= pcc_pkg::IDLE_INSTR;
      ip_r          <= '0;
      ip_pend_r     <= 1'b0;
      ip_pend_val_r <= '0;
      cyc_r         <= 32'h0000_0000;
      last_cyc_r    <= 32'h0000_0000;
      dst_r         <= '0;
      ar_req        <= 1'b0;
      ar_op         <= 8'h00;
      ar_a          <= '0;
      ar_b          <= '0;
      nt_valid      <= 1'b0;
      nt_hdr        <= 16'h0000;
      nt_tag        <= 3'h0;
      nt_data       <= '0;
      nt_last       <= 1'b0;
      nt_idx_r      <= '0;
      nt_rem_r      <= 4'h0;
    end
    else if (imem_clr)
    begin
      // program is gone: abandon the running instruction
      state_r   <= S_FETCH;
      ip_r      <= '0;
      ip_pend_r <= 1'b0;
      ar_req    <= 1'b0;
      nt_valid  <= 1'b0;
    end
    else
    begin
      cyc_r <= cyc_r + 32'h1;
      if (apb_ip_we)
      begin
        ip_pend_r     <= 1'b1;
        ip_pend_val_r <= pwdata[pcc_pkg::IM_AW-1:0];
      end
      unique case (state_r)
        S_FETCH:
        begin
          // pointer writes land only between instructions
          if (ip_pend_r)
          begin
            ip_r <= ip_pend_val_r;
            if (!apb_ip_we)
              ip_pend_r <= 1'b0;
          end
          else if (imem_r[ip_r].op != pcc_pkg::OP_IDLE)
          begin
            cur_r   <= imem_r[ip_r];
            state_r <= S_EXEC;
            cyc_r   <= 32'h1;
          end
        end
        S_EXEC:
        begin
          state_r    <= S_FETCH;
          last_cyc_r <= cyc_r;
          ip_r       <= ip_r + 1'b1;
          case (cur_r.op)
            pcc_pkg::OP_JUMP:
              ip_r <= cur_r.a[pcc_pkg::IM_AW-1:0];
            pcc_pkg::OP_JZ:
              if (b_zero)
                ip_r <= cur_r.a[pcc_pkg::IM_AW-1:0];
            pcc_pkg::OP_JEQ:
              if (b_eq_c)
                ip_r <= cur_r.a[pcc_pkg::IM_AW-1:0];
            pcc_pkg::OP_JNZ:
              if (!b_zero)
                ip_r <= cur_r.a[pcc_pkg::IM_AW-1:0];
            pcc_pkg::OP_NOTIFY:
            begin
              state_r  <= S_NOTIFY;
              ip_r     <= ip_r;
              nt_valid <= 1'b1;
              nt_hdr   <= cur_r.b;
              nt_tag   <= dmem_r[sa].tag;
              nt_data  <= dmem_r[sa];
              nt_idx_r <= sa;
              nt_rem_r <= pcc_pkg::slot_span(dmem_r[sa].tag) - 4'h1;
              nt_last  <= pcc_pkg::slot_span(dmem_r[sa].tag) == 4'h1;
            end
            pcc_pkg::OP_FMUL, pcc_pkg::OP_FADD, pcc_pkg::OP_FSUB,
            pcc_pkg::OP_PADD, pcc_pkg::OP_PMUL, pcc_pkg::OP_PAIRING,
            pcc_pkg::OP_FINV, pcc_pkg::OP_PNEG,
            pcc_pkg::OP_G1MUL, pcc_pkg::OP_G2MUL:
            begin
              // datapath owns the maths, affine or jacobian in, jacobian out
              state_r <= S_ARITH;
              ip_r    <= ip_r;
              ar_req  <= 1'b1;
              ar_op   <= cur_r.op;
              ar_a    <= dmem_r[sa];                   // plain form
              ar_b    <= dmem_r[sb];
              // unary forms write to b, binary forms to c
              if (cur_r.op == pcc_pkg::OP_FINV || cur_r.op == pcc_pkg::OP_PNEG
                  || cur_r.op == pcc_pkg::OP_G1MUL || cur_r.op == pcc_pkg::OP_G2MUL)
                dst_r <= sb;
              else
                dst_r <= sc;
            end
            default:
            begin
            end
          endcase
        end
        S_ARITH:
          if (ar_done)
          begin
            ar_req     <= 1'b0;
            state_r    <= S_FETCH;
            last_cyc_r <= cyc_r;
            ip_r       <= ip_r + 1'b1;
          end
        S_NOTIFY:
          if (nt_ready)
          begin
            if (nt_last)
            begin
              nt_valid   <= 1'b0;
              state_r    <= S_FETCH;
              last_cyc_r <= cyc_r;
              ip_r       <= ip_r + 1'b1;
            end
            else
            begin
              // consecutive slots of one operand
              nt_idx_r <= nt_idx_r + 1'b1;
              nt_data  <= dmem_r[nt_idx_r + 1'b1];
              nt_rem_r <= nt_rem_r - 4'h1;
              nt_last  <= nt_rem_r == 4'h1;
            end
          end
      endcase
    end
  end

endmodule

`default_nettype wire

// ===== pcc_seq_assertions.sv
// pcc_seq_assertions: port-level checks of the coprocessor sequencer.
// assumes a bind onto pcc_seq in a single pclk domain.
`timescale 1ns/1ps
`default_nettype none
module pcc_chk (
  // clock and reset
  input wire logic               pclk,
  input wire logic               presetn,
  // apb
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [15:0]        paddr,
  input wire logic               pready,
  input wire logic [31:0]        prdata,
  input wire logic               pslverr,
  // arithmetic unit and host sink
  input wire logic               ar_req,
  input wire logic [7:0]         ar_op,
  input wire pcc_pkg::pcc_slot_t ar_a,
  input wire pcc_pkg::pcc_slot_t ar_b,
  input wire logic               ar_done,
  input wire logic               nt_valid,
  input wire logic [15:0]        nt_hdr,
  input wire pcc_pkg::pcc_slot_t nt_data,
  input wire logic               nt_ready
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic rd_su = psel && !penable && !pwrite;

  rdy_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  rdy_single_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ctrl_read_a: assert property (rd_su && paddr == 16'h0000
    |=> prdata == 32'h0000_1000)
    else $error("control read wrong");
  dm_ofs_a: assert property (rd_su && paddr == 16'h0004 |=> prdata == 32'h0000_2000)
    else $error("data offset read wrong");
  unmapped_err_a: assert property (psel && !penable && paddr == 16'h0018 |=> pslverr)
    else $error("no error on unmapped access");
  ar_hold_a: assert property (ar_req && !ar_done |=> ar_req
    && $stable(ar_op) && $stable(ar_a) && $stable(ar_b))
    else $error("arith request changed early");
  ar_release_a: assert property (ar_req && ar_done |=> !ar_req)
    else $error("arith request not released");
  ar_op_legal_a: assert property ($rose(ar_req) |-> ar_op inside {8'h10, 8'h11,
    8'h12, 8'h13, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h28})
    else $error("arith opcode illegal");
  nt_hold_a: assert property (nt_valid && !nt_ready |=> nt_valid
    && $stable(nt_data) && $stable(nt_hdr))
    else $error("notify beat changed while stalled");
endmodule

bind pcc_seq pcc_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .ar_req(ar_req), .ar_op(ar_op), .ar_a(ar_a), .ar_b(ar_b), .ar_done(ar_done),
  .nt_valid(nt_valid), .nt_hdr(nt_hdr), .nt_data(nt_data), .nt_ready(nt_ready));
`default_nettype wire

// ===== pcc_far.sv
// pcc_far: behavioural arithmetic unit and host sink facing the sequencer.
// assumes the bench reads the recorded notify beats from its queues.
`timescale 1ns/1ps
`default_nettype none
module pcc_far (
  // clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // arithmetic unit
  input  wire logic               ar_req,
  input  wire logic [7:0]         ar_op,
  input  wire pcc_pkg::pcc_slot_t ar_a,
  input  wire pcc_pkg::pcc_slot_t ar_b,
  output logic                    ar_done,
  output pcc_pkg::pcc_slot_t      ar_res,
  // host sink
  input  wire logic               nt_valid,
  input  wire logic [15:0]        nt_hdr,
  input  wire pcc_pkg::pcc_slot_t nt_data,
  input  wire logic               nt_last,
  output logic                    nt_ready
);
  pcc_pkg::pcc_slot_t beats [$];
  logic [15:0]        hdrs [$];
  logic               lasts [$];
  pcc_pkg::pcc_slot_t res;
  int                 wait_n;
  int                 dly;

  // stand-in result: unary ops ignore slot b
  always_comb
  begin
    res = ar_a;
    res.val = ar_a.val + 381'(ar_op);
    if (!(ar_op inside {8'h13, 8'h20, 8'h23, 8'h24})) res.val = res.val + ar_b.val;
  end

  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ar_done <= 1'b0;
      ar_res <= '0;
      wait_n <= 0;
      dly <= 0;
      nt_ready <= 1'b0;
    end
    else
    begin
      ar_done <= 1'b0;
      ar_res <= ~ar_res;  // not a stale value outside the answer
      if (ar_req && !ar_done)
      begin
        if (wait_n == dly)
        begin
          ar_done <= 1'b1;
          ar_res <= res;
          wait_n <= 0;
          dly <= (dly + 1) % 4;  // prompt and slow answers in turn
        end
        else
          wait_n <= wait_n + 1;
      end
      nt_ready <= ~nt_ready;  // host stalls every other cycle
      if (nt_valid && nt_ready)
      begin
        beats.push_back(nt_data);
        hdrs.push_back(nt_hdr);
        lasts.push_back(nt_last);
      end
    end
endmodule
`default_nettype wire

// ===== tb_pcc_seq.sv
// tb_pcc_seq: self-checking bench for the coprocessor sequencer.
// assumes pcc_far on the far side and the checker bound in.
`timescale 1ns/1ps
`default_nettype none
module tb_pcc_seq;
  logic               pclk = 1'b0;
  logic               presetn = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [15:0]        paddr = 16'h0000;
  logic [31:0]        pwdata = 32'h0000_0000;
  logic               pready, pslverr, ar_req, ar_done, nt_valid, nt_last, nt_ready;
  logic [31:0]        prdata, rdv;
  logic [7:0]         ar_op;
  logic [15:0]        nt_hdr;
  logic [2:0]         nt_tag;
  pcc_pkg::pcc_slot_t ar_a, ar_b, ar_res, nt_data, got;
  pcc_pkg::pcc_slot_t exp_dm [16];
  logic               rer;
  int                 seed = 19;
  int                 fail_count = 0;
  int                 comparisons = 0;
  localparam logic [7:0]  OPS [10] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h20, 8'h21, 8'h22,
                                       8'h23, 8'h24, 8'h28};
  localparam logic [31:0] REXP [4] = '{32'h0000_1000, 32'h0000_2000, 32'h4, 32'h4};

  always #2 pclk = ~pclk;
  pcc_seq i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .ar_req(ar_req), .ar_op(ar_op), .ar_a(ar_a), .ar_b(ar_b),
    .ar_done(ar_done), .ar_res(ar_res), .nt_valid(nt_valid), .nt_hdr(nt_hdr),
    .nt_tag(nt_tag), .nt_data(nt_data), .nt_last(nt_last), .nt_ready(nt_ready));
  pcc_far i_far (.pclk(pclk), .presetn(presetn), .ar_req(ar_req), .ar_op(ar_op),
    .ar_a(ar_a), .ar_b(ar_b), .ar_done(ar_done), .ar_res(ar_res), .nt_valid(nt_valid),
    .nt_hdr(nt_hdr), .nt_data(nt_data), .nt_last(nt_last), .nt_ready(nt_ready));

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic err(input string m);
    fail_count++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) err($sformatf("word got %h expected %h", g, e));
  endtask
  task automatic chk_slot(input pcc_pkg::pcc_slot_t g, input pcc_pkg::pcc_slot_t e);
    comparisons++;
    if (g !== e) err("slot contents differ");
  endtask
  // one apb transfer; called just after a rising edge
  task automatic apb(input logic wr, input logic [15:0] ad, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 50)
    begin
      err("bus wait ran out");
      give_verdict();
    end
    rdv = prdata;
    rer = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so the next call never drives psel twice in one instant
    @(posedge pclk);
  endtask
  function automatic logic [15:0] sad(input int s, input int w);
    return 16'h2000 + 16'(s * 64 + w * 4);
  endfunction
  task automatic wslot(input int s);
    for (int w = 0; w < 12; w++) apb(1'b1, sad(s, w), exp_dm[s][32*w+:32]);
  endtask
  task automatic rslot(input int s);
    for (int w = 0; w < 12; w++)
    begin
      apb(1'b0, sad(s, w), 32'h0);
      got[32*w+:32] = rdv;
    end
  endtask
  // high word first: the opcode lands last, so no half-written instruction runs
  task automatic winstr(input int i, input logic [7:0] op, input int a, input int b,
                        input int c);
    pcc_pkg::pcc_instr_t x;
    x = '{8'h00, 16'(c), 16'(b), 16'(a), op};
    apb(1'b1, 16'h1004 + 16'(i * 8), x[63:32]);
    apb(1'b1, 16'h1000 + 16'(i * 8), x[31:0]);
  endtask
  task automatic wait_ip(input int t);
    int n;
    for (n = 0; n < 300; n++)
    begin
      apb(1'b0, pcc_pkg::REG_IP, 32'h0);
      if (rdv === 32'(t)) break;
    end
    if (n == 300)
    begin
      err("pointer never reached target");
      give_verdict();
    end
  endtask
  function automatic logic un(input logic [7:0] o);
    return o inside {8'h13, 8'h20, 8'h23, 8'h24};
  endfunction
  function automatic int span(input logic [2:0] t);
    case (t)
      3'd2, 3'd4: return 2;
      3'd3:       return 12;
      3'd5:       return 3;
      3'd6:       return 4;
      3'd7:       return 6;
      default:    return 1;
    endcase
  endfunction

  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, 16'(4 * i), 32'h0);
      chk_reg(rdv, REXP[i]);
    end
    for (int i = 0; i < 16; i++)
    begin
      apb(1'b0, 16'h1000 + 16'(i * 8), 32'h0);
      chk_reg(rdv, 32'h0);
    end
    apb(1'b0, 16'h0018, 32'h0);
    chk_reg(32'(rer), 32'h1);
    $display("test registers done");
    for (int s = 0; s < 16; s++)
    begin
      for (int w = 0; w < 12; w++) exp_dm[s][32*w+:32] = $random(seed);
      wslot(s);
    end
    // inputs 1 and 3 never double as a destination
    for (int i = 9; i >= 0; i--)
    begin
      winstr(i, OPS[i], 1, un(OPS[i]) ? 4 + i : 3, 4 + i);
    end
    for (int i = 0; i < 10; i++)
    begin
      exp_dm[4+i] = exp_dm[1];
      exp_dm[4+i].val = exp_dm[1].val + 381'(OPS[i]) + (un(OPS[i]) ? '0 : exp_dm[3].val);
    end
    wait_ip(10);
    apb(1'b0, pcc_pkg::REG_IP, 32'h0);
    chk_reg(rdv, 32'd10);
    for (int s = 1; s < 14; s++)
    begin
      rslot(s);
      chk_slot(got, exp_dm[s]);
    end
    $display("test arithmetic done");
    apb(1'b1, pcc_pkg::REG_CTRL, 32'h1);
    apb(1'b0, 16'h1000, 32'h0);
    chk_reg(rdv, 32'h0);
    apb(1'b0, pcc_pkg::REG_IP, 32'h0);
    chk_reg(rdv, 32'h0);
    exp_dm[0] = '0;
    exp_dm[6] = {pcc_pkg::TAG_SCALAR, 381'd2};
    exp_dm[7].tag = pcc_pkg::TAG_G1_JAC;
    wslot(0);
    wslot(6);
    wslot(7);
    winstr(11, 8'h02, 14, 0, 0);
    winstr(10, 8'h07, 0, 0, 0);
    winstr(9, 8'h05, 0, 0, 0);
    winstr(8, 8'h03, 0, 6, 0);
    winstr(6, 8'h04, 8, 1, 2);
    winstr(4, 8'h03, 6, 0, 0);
    winstr(3, 8'h06, 7, 16'hA5C3, 0);
    winstr(1, 8'h05, 3, 6, 0);
    winstr(0, 8'h01, 1, 2, 0);
    exp_dm[2] = exp_dm[1];
    exp_dm[6].val = 381'd1;
    wait_ip(14);
    apb(1'b0, pcc_pkg::REG_IP, 32'h0);
    chk_reg(rdv, 32'd14);
    for (int s = 0; s < 8; s++)
    begin
      rslot(s);
      chk_slot(got, exp_dm[s]);
    end
    chk_reg(32'(i_far.beats.size()), 32'(span(pcc_pkg::TAG_G1_JAC)));
    for (int k = 0; k < i_far.beats.size() && k < 3; k++)
    begin
      chk_slot(i_far.beats[k], exp_dm[7+k]);
      chk_reg({15'h0, i_far.lasts[k], i_far.hdrs[k]}, {15'h0, k == 2, 16'hA5C3});
    end
    // tag of the first slot of the last notify stands until the next notify
    chk_reg(32'(nt_tag), 32'(pcc_pkg::TAG_G1_JAC));
    $display("test control flow done");
    apb(1'b1, pcc_pkg::REG_IP, 32'd15);
    wait_ip(15);
    apb(1'b0, pcc_pkg::REG_IP, 32'h0);
    chk_reg(rdv, 32'd15);
    $display("test stall done");
    apb(1'b1, sad(2, 12), 32'hFFFF_FFFF);
    apb(1'b0, sad(2, 12), 32'h0);
    chk_reg(rdv, 32'h0);
    chk_reg(32'(rer), 32'h0);
    apb(1'b1, pcc_pkg::REG_CTRL, 32'h2);
    rslot(1);
    chk_slot(got, '0);
    $display("test memory clear done");
    give_verdict();
  end
endmodule
`default_nettype wire
